// ==== src/programmable_pin_output_control.sv ====
// Operation
// - pin 0 field: direct, write-gated, decode
// - pin 1 field: direct, read-gated, decode
// - pin 2 field: power level, write-gated, decode
// - pin 3 field: power level, read-gated, decode
// - power setting: Off gives inverse bit 7
// - decode compares only address bits 9..3
// - pin 2 high outside Off mode
// - pin 2 in Off: bit7 1 low
// - pin 2 decode low while address matches
// - pin 2 is output only
// - pin 2 register write-only: level, match
// - pin 0 direct: bit7 1 drives low
// - pin 0 decode low while address matches
// - pin 1 direct like pin 0
// - pin 3 in Off gives inverse bit 7
module programmable_pin_output_control
  import pin_output_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // avalon-mm register slave
  input  wire logic [BUS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [BUS_DATA_W-1:0] avs_writedata,
  input  wire logic [BUS_BE_W-1:0]   avs_byteenable,
  output logic      [BUS_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  // system i/o cycle and power manager
  input  wire logic [IO_ADDR_W-1:0]  ioAddr,
  input  wire logic                  ioWrCmd_n,
  input  wire logic                  ioRdCmd_n,
  input  wire logic                  pmOff,
  // programmable pins, output only
  output logic      [PIN_COUNT-1:0]  programmablePin
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  bus_state_t              busState_q;
  bus_state_t              busState_d;
  logic                    waitReq_q;
  logic                    waitReq_d;
  logic [BUS_DATA_W-1:0]   readData_q;
  logic [BUS_DATA_W-1:0]   readData_d;
  logic                    writeCommit;
  logic                    lowLaneOn;
  logic [REG_W-1:0]        gateCtrl_q;
  logic [REG_W-1:0]        gateCtrl_d;
  logic                    pinWrEn;
  logic [PIN_SEL_W-1:0]    pinWrSel;
  logic [REG_W-1:0]        pinWord [PIN_COUNT];
  logic [PIN_COUNT-1:0]    pin_q;
  logic [PIN_COUNT-1:0]    pin_d;
  logic [BUS_DATA_W-1:0]   statusWord;
  logic [PIN_COUNT*MODE_W-1:0] modeView;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: every access costs one wait cycle; waitrequest drops for exactly
  // one cycle and the write lands on the edge that closes that cycle
  always_comb
  begin
    busState_d = busState_q;
    waitReq_d  = 1'b1;
    readData_d = readData_q;
    unique case (busState_q)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          busState_d = BUS_ANSWER;
          waitReq_d  = 1'b0;
          // documented registers are write-only, so they read back as zero
          readData_d = (avs_read && reg_hit(avs_address, IDX_PIN_STATUS)) ? statusWord : '0;
        end
      end
      BUS_ANSWER:
      begin
        busState_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busState_q <= BUS_IDLE;
      waitReq_q  <= 1'b1;
      readData_q <= '0;
    end
    else
    begin
      busState_q <= busState_d;
      waitReq_q  <= waitReq_d;
      readData_q <= readData_d;
    end
  end

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata    = readData_q;

  // the master holds address and data until it sees waitrequest low, so the
  // live bus values are still valid at the committing edge
  assign lowLaneOn   = avs_byteenable[0];
  assign writeCommit = (busState_q == BUS_ANSWER) && avs_write && lowLaneOn;

  ////////////////////////////////////////////////////////////////////////////
  // gate-control register, write-only, steers the mode of every pin
  always_comb
  begin
    gateCtrl_d = gateCtrl_q;
    if (writeCommit && reg_hit(avs_address, IDX_GATE_CTRL))
      gateCtrl_d = avs_writedata[REG_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gateCtrl_q <= GATE_CTRL_RESET;
    else
      gateCtrl_q <= gateCtrl_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin registers: level bit and match value, write-only, one slot per pin
  always_comb
  begin
    pinWrEn  = 1'b0;
    pinWrSel = '0;
    if (writeCommit)
    begin
      if (reg_hit(avs_address, IDX_PIN0_REG))
      begin
        pinWrEn  = 1'b1;
        pinWrSel = 2'h0;
      end
      else if (reg_hit(avs_address, IDX_PIN1_REG))
      begin
        pinWrEn  = 1'b1;
        pinWrSel = 2'h1;
      end
      else if (reg_hit(avs_address, IDX_PIN2_REG))
      begin
        pinWrEn  = 1'b1;
        pinWrSel = 2'h2;
      end
      else if (reg_hit(avs_address, IDX_PIN3_REG))
      begin
        pinWrEn  = 1'b1;
        pinWrSel = 2'h3;
      end
    end
  end

  pin_word_store u_pin_word_store (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wrEn    (pinWrEn),
    .wrSel   (pinWrSel),
    .wrData  (avs_writedata[REG_W-1:0]),
    .word_q  (pinWord)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-pin output selection; pins are active low, high means idle
  genvar gp;
  generate
    for (gp = 0; gp < PIN_COUNT; gp++)
    begin : g_pin
      pin_mode_t  mode;
      logic       addrMatch;
      logic       strobeOn;
      logic       levelBit;

      // only address bits 9..3 take part, everything else is ignored
      assign addrMatch = ioAddr[IO_ADDR_MSB:IO_ADDR_LSB] == pinWord[gp][MATCH_MSB:MATCH_LSB];
      assign strobeOn  = WRITE_GATED_PINS[gp] ? !ioWrCmd_n : !ioRdCmd_n;
      assign levelBit  = pinWord[gp][LEVEL_BIT];
      assign mode      = field_to_mode(gp, gateCtrl_q[gp*MODE_W +: MODE_W]);
      assign modeView[gp*MODE_W +: MODE_W] = mode;

      // next pin level from the selected mode
      always_comb
      begin
        pin_d[gp] = 1'b1;
        unique case (mode)
          MODE_LEVEL:
          begin
            if (PM_LEVEL_PINS[gp])
              // high outside Off; inside Off the inverse of the level bit
              pin_d[gp] = pmOff ? !levelBit : 1'b1;
            else
              // direct drive: level bit 1 pulls the pin low
              pin_d[gp] = !levelBit;
          end
          MODE_GATED:
          begin
            // low only while match and the command strobe overlap
            pin_d[gp] = !(addrMatch && strobeOn);
          end
          MODE_DECODE:
          begin
            // plain decode; the board must add its own command qualification
            pin_d[gp] = !addrMatch;
          end
        endcase
      end
    end
  endgenerate

  // outputs come from flops, so every pin lags its cause by one clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pin_q <= PIN_OUT_RESET;
    else
      pin_q <= pin_d;
  end

  // pins are driven at all times with no input path back into the block
  assign programmablePin = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // status word: current pin levels, power state and decoded pin modes
  always_comb
  begin
    statusWord = '0;
    statusWord[STAT_PIN_LSB +: PIN_COUNT]       = pin_q;
    statusWord[STAT_OFF_BIT]                    = pmOff;
    statusWord[STAT_MODE_LSB +: PIN_COUNT*MODE_W] = modeView;
  end

endmodule // programmable_pin_output_control

// ==== src/pin_output_pkg.sv ====
package pin_output_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_PIN0_REG      = 8'h89;
  localparam logic [7:0] IDX_GATE_CTRL     = 8'h91;
  localparam logic [7:0] IDX_PIN2_REG      = 8'h94;
  localparam logic [7:0] IDX_PIN3_REG      = 8'h95;
  localparam logic [7:0] IDX_PIN1_REG      = 8'h9c;
  localparam logic [7:0] IDX_PIN_STATUS    = 8'hc0;

  // bus geometry
  localparam int         BUS_ADDR_W        = 10;
  localparam int         BUS_DATA_W        = 32;
  localparam int         BUS_BE_W          = 4;
  localparam int         BYTE_SHIFT        = 2;

  ////////////////////////////////////////////////////////////////////////////
  // pin register layout
  localparam int         PIN_COUNT         = 4;
  localparam int         PIN_SEL_W         = 2;
  localparam int         REG_W             = 8;
  localparam int         LEVEL_BIT         = 7;
  localparam int         MATCH_MSB         = 6;
  localparam int         MATCH_LSB         = 0;
  localparam int         IO_ADDR_W         = 10;
  localparam int         IO_ADDR_MSB       = 9;
  localparam int         IO_ADDR_LSB       = 3;

  // gate-control layout: two bits per pin, pin n at bits 2n+1:2n
  localparam int         MODE_W            = 2;
  localparam logic [1:0] MODE_LEVEL_CODE   = 2'b00;
  localparam logic [1:0] GATE_CODE_WRITE   = 2'b10;
  localparam logic [1:0] GATE_CODE_READ    = 2'b01;
  // pins 0 and 2 gate with the write strobe, pins 1 and 3 with the read strobe
  localparam logic [3:0] WRITE_GATED_PINS  = 4'h5;
  // pins 2 and 3 take the power-manager level in the 00 setting
  localparam logic [3:0] PM_LEVEL_PINS     = 4'hc;

  // reset values
  localparam logic [7:0] GATE_CTRL_RESET   = 8'h00;
  localparam logic [7:0] PIN_REG_RESET     = 8'h00;
  localparam logic [3:0] PIN_OUT_RESET     = 4'hf;

  // status layout
  localparam int         STAT_PIN_LSB      = 0;
  localparam int         STAT_OFF_BIT      = 4;
  localparam int         STAT_MODE_LSB     = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {MODE_LEVEL, MODE_GATED, MODE_DECODE} pin_mode_t;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

  // turns a pin's two-bit field into its operating mode
  function automatic pin_mode_t field_to_mode(input int pin, input logic [1:0] field);
    logic [1:0] gateCode;
    gateCode = WRITE_GATED_PINS[pin] ? GATE_CODE_WRITE : GATE_CODE_READ;
    if (field == MODE_LEVEL_CODE)
      return MODE_LEVEL;
    else if (field == gateCode)
      return MODE_GATED;
    else
      return MODE_DECODE;
  endfunction

  // true when a bus byte address selects the given register index
  function automatic logic reg_hit(input logic [BUS_ADDR_W-1:0] addr, input logic [7:0] idx);
    return addr[BUS_ADDR_W-1:BYTE_SHIFT] == idx;
  endfunction

endpackage

// ==== src/pin_word_store.sv ====
module pin_word_store
  import pin_output_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // write port
  input  wire logic                 wrEn,
  input  wire logic [PIN_SEL_W-1:0] wrSel,
  input  wire logic [REG_W-1:0]     wrData,
  // stored words, straight from the flops
  output logic      [REG_W-1:0]     word_q [PIN_COUNT]
);

  logic [REG_W-1:0] word_d [PIN_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // next value of each word: only the selected slot takes the write
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      word_d[i] = word_q[i];
      if (wrEn && (wrSel == PIN_SEL_W'(i)))
        word_d[i] = wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < PIN_COUNT; i++)
        word_q[i] <= PIN_REG_RESET;
    end
    else
    begin
      for (int i = 0; i < PIN_COUNT; i++)
        word_q[i] <= word_d[i];
    end
  end

endmodule // pin_word_store

// ==== testbench/programmable_pin_output_control_asserts.sv ====
module programmable_pin_output_control_asserts
  import pin_output_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  // register bus
  input wire logic [BUS_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [BUS_DATA_W-1:0] avs_readdata,
  input wire logic                  avs_waitrequest,
  // i/o cycle, power manager and pins
  input wire logic [IO_ADDR_W-1:0]  ioAddr,
  input wire logic                  ioWrCmd_n,
  input wire logic                  ioRdCmd_n,
  input wire logic                  pmOff,
  input wire logic [PIN_COUNT-1:0]  programmablePin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // bus handshake
  ans_bound_a: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest) else $error("no answer");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  no_spur_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("answer unasked");
  rd_stand_a: assert property ($rose(avs_waitrequest) && $past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved");
  // write-only places and unmapped places read as zero
  rd_zero_a: assert property (!avs_waitrequest && avs_read && avs_address[9:2] != IDX_PIN_STATUS
    |-> avs_readdata == 32'h0) else $error("write-only read nonzero");
  stat_upper_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read bits set");
  // no pin field ever decodes to an unused mode
  stat_mode_a: assert property (!avs_waitrequest && avs_read && avs_address[9:2] == IDX_PIN_STATUS
    |-> avs_readdata[9:8] != 2'h3 && avs_readdata[11:10] != 2'h3 && avs_readdata[13:12] != 2'h3
    && avs_readdata[15:14] != 2'h3) else $error("bad mode code");
  // status returns the pins and power state seen at the edge that took the read
  stat_pin_a: assert property (!avs_waitrequest && avs_read && avs_address[9:2] == IDX_PIN_STATUS
    |-> avs_readdata[4:0] == {$past(pmOff), $past(programmablePin)}) else $error("status pins wrong");
  // without a new cause the pins hold still
  pin_hold_a: assert property ($stable(ioAddr) && $stable(ioWrCmd_n) && $stable(ioRdCmd_n)
    && $stable(pmOff) && !avs_write && !$past(avs_write) |=> $stable(programmablePin)) else $error("pin moved");
  ////////////////////////////////////////////////////////////////////////////
  c_write: cover property (avs_write && !avs_waitrequest);
  c_read: cover property (avs_read && !avs_waitrequest);
  c_pin_low: cover property ($fell(programmablePin[2]));
endmodule // programmable_pin_output_control_asserts

bind programmable_pin_output_control programmable_pin_output_control_asserts i_asserts (.clk_sys, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .ioAddr, .ioWrCmd_n, .ioRdCmd_n,
  .pmOff, .programmablePin);

// ==== testbench/board_pin_sink.sv ====
module board_pin_sink
  import pin_output_pkg::*;
(
  // pins and strobes from the system
  input  wire logic [PIN_COUNT-1:0] programmablePin,
  input  wire logic                 ioWrCmd_n,
  input  wire logic                 ioRdCmd_n,
  // qualified selects to board devices
  output logic      [PIN_COUNT-1:0] boardSel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // a plain decode is only a select while a command strobe runs
  assign boardSel_n = programmablePin | {PIN_COUNT{ioWrCmd_n & ioRdCmd_n}};
endmodule // board_pin_sink

// ==== testbench/test_programmable_pin_output_control.sv ====
module test_programmable_pin_output_control;
  import pin_output_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [BUS_ADDR_W-1:0] avs_address = '0;
  logic [BUS_DATA_W-1:0] avs_writedata = '0, avs_readdata, rdWord;
  logic [BUS_BE_W-1:0]   avs_byteenable = 4'hf;
  logic [IO_ADDR_W-1:0]  ioAddr = '0;
  logic ioWrCmd_n = 1'b1, ioRdCmd_n = 1'b1, pmOff = 1'b0;
  logic [PIN_COUNT-1:0]  programmablePin, boardSel_n;
  int badCount = 0, samplesChecked = 0, cycles = 0;
  logic [7:0] pinIdx [4] = '{IDX_PIN0_REG, IDX_PIN1_REG, IDX_PIN2_REG, IDX_PIN3_REG};
  logic [3:0] caseTab [4] = '{4'b1110, 4'b1011, 4'b1100, 4'b0001}; // match, wr_n, rd_n, off
  programmable_pin_output_control i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ioAddr, .ioWrCmd_n, .ioRdCmd_n, .pmOff, .programmablePin);
  board_pin_sink i_board (.programmablePin, .ioWrCmd_n, .ioRdCmd_n, .boardSel_n);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // a hang costs a mismatch, not a stuck run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      badCount++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (badCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pins(input logic [3:0] got, input logic [3:0] exp);
    check_word({28'h0, got}, {28'h0, exp});
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdWord = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // every code of each pin's field against match, strobes and off mode
  task automatic t_pin_modes(input int p);
    logic [6:0] m;
    logic [1:0] g;
    logic [3:0] ex;
    logic [3:0] cs;
    logic low;
    m = 7'h2a + 7'(p);
    g = p[0] ? GATE_CODE_READ : GATE_CODE_WRITE;
    bus_xfer(1'b1, pinIdx[p], {1'b1, m}, 4'hf);
    for (int c = 0; c < 4; c++)
    begin
      bus_xfer(1'b1, IDX_GATE_CTRL, 8'(c << (2 * p)), 4'hf);
      for (int k = 0; k < 4; k++)
      begin
        cs = caseTab[k];
        @(posedge clk_sys);
        ioAddr <= {cs[3] ? m : m ^ 7'h01, 3'(k)};
        ioWrCmd_n <= cs[2];
        ioRdCmd_n <= cs[1];
        pmOff <= cs[0];
        repeat (3) @(posedge clk_sys);
        if (c == 0)
          low = (p < 2) | cs[0];
        else if (2'(c) == g)
          low = cs[3] & !(p[0] ? cs[1] : cs[2]);
        else
          low = cs[3];
        ex = 4'hf;
        ex[p] = !low;
        check_pins(programmablePin, ex);
        check_pins(boardSel_n, ex | {4{cs[2] & cs[1]}});
      end
      bus_xfer(1'b0, IDX_PIN_STATUS, 8'h0, 4'hf);
      check_word(rdWord, {16'h0, 8'((c == 0 ? 0 : 2'(c) == g ? 1 : 2) << (2 * p)), 3'h0, cs[0], ex});
    end
    bus_xfer(1'b1, pinIdx[p], 8'h00, 4'hf);
  endtask
  // write-only and unmapped places read zero; a write without byte 0 is dropped
  task automatic t_refused();
    foreach (pinIdx[i])
    begin
      bus_xfer(1'b0, pinIdx[i], 8'h0, 4'hf);
      check_word(rdWord, 32'h0);
    end
    bus_xfer(1'b1, IDX_PIN0_REG, 8'h80, 4'he);
    bus_xfer(1'b1, 8'h00, 8'h80, 4'hf);
    bus_xfer(1'b0, 8'h00, 8'h0, 4'hf);
    check_word(rdWord, 32'h0);
    check_pins(programmablePin, 4'hf);
  endtask
  // a reset in mid-run restores direct and level modes; pins 0 and 2 are pulled
  // low first, and off mode stays on, so a register that misses reset shows up
  task automatic t_second_reset();
    @(posedge clk_sys);
    ioAddr <= {7'h35, 3'h0};
    pmOff <= 1'b1;
    bus_xfer(1'b1, IDX_GATE_CTRL, 8'h10, 4'hf);
    bus_xfer(1'b1, IDX_PIN2_REG, 8'hb5, 4'hf);
    bus_xfer(1'b1, IDX_PIN0_REG, 8'h80, 4'hf);
    repeat (3) @(posedge clk_sys);
    check_pins(programmablePin, 4'ha);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    ioAddr <= '0;
    repeat (3) @(posedge clk_sys);
    check_pins(programmablePin, 4'hf);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check_pins(programmablePin, 4'hf);
    // first access straight after release: pins high, Off bit set, modes zero
    bus_xfer(1'b0, IDX_PIN_STATUS, 8'h0, 4'hf);
    check_word(rdWord, 32'h0000001f);
    repeat (2) @(posedge clk_sys);
    check_pins(programmablePin, 4'hf);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_pins(programmablePin, 4'hf);
    t_refused();
    for (int p = 0; p < 4; p++)
      t_pin_modes(p);
    t_second_reset();
    end_of_test();
  end
endmodule // test_programmable_pin_output_control
